//--- include/ctf_cfg.svh
// constants for the cpu thermal fan configuration register bank
`ifndef CTF_CFG_SVH
`define CTF_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CTF_ADDR_LINK_CFG 8'h37
`define CTF_ADDR_FAN1_MAX 8'h38
`define CTF_ADDR_FAN2_MAX 8'h39
`define CTF_ADDR_FAN3_MAX 8'h3A
`define CTF_ADDR_RAMP_START 8'h3B
`define CTF_ADDR_RAMP_SPAN 8'h3C

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define CTF_RST_LINK_CFG 8'h32
`define CTF_RST_MAX_DUTY 8'hFF
`define CTF_RST_RAMP_START 8'h80
`define CTF_RST_RAMP_SPAN 8'hC0
`define CTF_WMASK_LINK_CFG 8'hB3
`define CTF_WMASK_RAMP_SPAN 8'hF0

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTF_BIT_FOUND 0
`define CTF_BIT_RETRY_SUP 1
`define CTF_RATE_LO 4
`define CTF_RATE_HI 5
`define CTF_BIT_WR_PERMIT 7
`define CTF_SPAN_LO 4
`define CTF_SPAN_HI 7

// ----------------------------------------
// timing
// ----------------------------------------
`define CTF_CLK_MHZ 100
`define CTF_CYC_PER_MS (`CTF_CLK_MHZ * 1000)
`define CTF_RATE0_MS 1000
`define CTF_RATE1_MS 500
`define CTF_RATE2_MS 200
`define CTF_RATE3_MS 100

`endif

//--- include/ctf_pkg.sv
// types for the cpu thermal fan configuration register bank
package ctf_pkg;

    // ----------------------------------------
    // register bank state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] link_cfg;
        logic [2:0][7:0] max_duty;
        logic [7:0] ramp_start;
        logic [7:0] ramp_span;
        logic [7:0] cpu_temp;
        logic [7:0] rdata;
        logic rvalid;
        logic poll_req;
    } ctf_top_st_t;

    // ----------------------------------------
    // poll timer state
    // ----------------------------------------
    typedef struct packed {
        logic [16:0] cyc;
        logic [9:0] ms;
        logic tick;
    } ctf_tmr_st_t;

    // ----------------------------------------
    // ramp state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] duty;
    } ctf_ramp_st_t;

endpackage

//--- hdl/ctf_poll_timer.sv
// poll interval timer for the cpu thermal link
`timescale 1ns/1ns
`include "ctf_cfg.svh"
module ctf_poll_timer #(
    parameter int CYC_PER_MS = `CTF_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic [1:0] rate_sel,
    output logic tick
);
    if (CYC_PER_MS < 1 || CYC_PER_MS > 131072) begin : g_chk
        $error("CYC_PER_MS out of range");
    end

    localparam logic [16:0] CYC_LAST = 17'(CYC_PER_MS - 1);

    ctf_pkg::ctf_tmr_st_t st;
    ctf_pkg::ctf_tmr_st_t next_st;
    logic [9:0] ms_last;

    // ----------------------------------------
    // interval select
    // ----------------------------------------
    always_comb begin
        case (rate_sel)
            2'h0: ms_last = 10'(`CTF_RATE0_MS - 1);
            2'h1: ms_last = 10'(`CTF_RATE1_MS - 1);
            2'h2: ms_last = 10'(`CTF_RATE2_MS - 1);
            default: ms_last = 10'(`CTF_RATE3_MS - 1);
        endcase
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!enable) begin
            next_st.cyc = 17'h0;
            next_st.ms = 10'h0;
        end else if (st.cyc >= CYC_LAST) begin
            next_st.cyc = 17'h0;
            if (st.ms >= ms_last) begin
                next_st.ms = 10'h0;
                next_st.tick = 1'b1;
            end else begin
                next_st.ms = st.ms + 10'h1;
            end
        end else begin
            next_st.cyc = st.cyc + 17'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_tick_needs_enable;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && !enable |=> !tick;
    endproperty
    a_tick_needs_enable: assert property (p_tick_needs_enable) else $error("poll tick while disabled");

    property p_tick_single;
        @(posedge core_clk) disable iff (!arst_n)
        tick && clk_en |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("poll tick longer than one cycle");

    property p_tick_at_wrap;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && enable && st.cyc >= CYC_LAST && st.ms >= ms_last |=> tick;
    endproperty
    a_tick_at_wrap: assert property (p_tick_at_wrap) else $error("poll tick missing at interval end");
endmodule // ctf_poll_timer

//--- hdl/ctf_duty_ramp.sv
// linear duty ramp for one fan output
`timescale 1ns/1ns
module ctf_duty_ramp (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] temp,
    input wire logic [7:0] start_temp,
    input wire logic [3:0] ramp_span_sel,
    input wire logic [7:0] floor_duty,
    input wire logic [7:0] max_duty,
    output logic [7:0] duty
);
    ctf_pkg::ctf_ramp_st_t st;
    ctf_pkg::ctf_ramp_st_t next_st;
    logic signed [8:0] delta;
    logic [7:0] recip;
    logic [16:0] frac;
    logic [7:0] base;
    logic [7:0] rng;
    logic [15:0] prod;

    // ----------------------------------------
    // 256 / span in degrees
    // ----------------------------------------
    always_comb begin
        case (ramp_span_sel)
            4'h0: recip = 8'h80;
            4'h1: recip = 8'h66;
            4'h2: recip = 8'h4D;
            4'h3: recip = 8'h40;
            4'h4: recip = 8'h33;
            4'h5: recip = 8'h26;
            4'h6: recip = 8'h20;
            4'h7: recip = 8'h1A;
            4'h8: recip = 8'h13;
            4'h9: recip = 8'h10;
            4'hA: recip = 8'h0D;
            4'hB: recip = 8'h0A;
            4'hC: recip = 8'h08;
            4'hD: recip = 8'h06;
            4'hE: recip = 8'h05;
            default: recip = 8'h03;
        endcase
    end

    // ----------------------------------------
    // duty from temperature
    // ----------------------------------------
    always_comb begin
        next_st = st;
        delta = $signed({temp[7], temp}) - $signed({start_temp[7], start_temp});
        frac = 17'($unsigned(delta) * recip);
        base = (max_duty < floor_duty) ? max_duty : floor_duty;
        rng = max_duty - base;
        prod = rng * frac[7:0];
        if (delta <= 9'sh0) begin
            next_st.duty = 8'h00;
        end else if (frac >= 17'h100) begin
            next_st.duty = max_duty;
        end else begin
            next_st.duty = base + prod[15:8];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign duty = st.duty;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_off_below_start;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && ($signed(temp) <= $signed(start_temp)) |=> duty == 8'h00;
    endproperty
    a_off_below_start: assert property (p_off_below_start) else $error("fan on below start temperature");

    property p_floor_above_start;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && ($signed(temp) > $signed(start_temp)) && floor_duty <= max_duty
        |=> duty >= $past(floor_duty) && duty <= $past(max_duty);
    endproperty
    a_floor_above_start: assert property (p_floor_above_start) else $error("duty outside floor and cap");
endmodule // ctf_duty_ramp

//--- hdl/ctf_cpu_thermal_fan_config_regs.sv
// cpu thermal link configuration and fan ramp register bank
`timescale 1ns/1ns
`include "ctf_cfg.svh"
module ctf_cpu_thermal_fan_config_regs #(
    parameter int CYC_PER_MS = `CTF_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic detect_done,
    input wire logic detect_found,
    input wire logic cpu_poll_enable,
    input wire logic [7:0] cpu_temp,
    input wire logic cpu_temp_valid,
    output logic poll_req,
    output logic retry_allow,
    input wire logic cpu_wr_req,
    output logic cpu_wr_grant,
    input wire logic [2:0][7:0] floor_duty,
    output logic [2:0][7:0] auto_duty
);
    ctf_pkg::ctf_top_st_t st;
    ctf_pkg::ctf_top_st_t next_st;
    logic tick;
    logic wr_link;
    logic wr_start;
    logic wr_span;
    logic [2:0] wr_max;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    assign wr_link = reg_wr && reg_addr == `CTF_ADDR_LINK_CFG;
    assign wr_start = reg_wr && reg_addr == `CTF_ADDR_RAMP_START;
    assign wr_span = reg_wr && reg_addr == `CTF_ADDR_RAMP_SPAN;
    assign wr_max[0] = reg_wr && reg_addr == `CTF_ADDR_FAN1_MAX;
    assign wr_max[1] = reg_wr && reg_addr == `CTF_ADDR_FAN2_MAX;
    assign wr_max[2] = reg_wr && reg_addr == `CTF_ADDR_FAN3_MAX;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.rvalid = reg_rd;
        next_st.poll_req = tick && cpu_poll_enable;
        if (wr_link) begin
            // reserved bits keep zero
            next_st.link_cfg = reg_wdata & `CTF_WMASK_LINK_CFG;
        end
        if (detect_done) begin
            // link result wins over a software write in the same cycle
            next_st.link_cfg[`CTF_BIT_FOUND] = detect_found;
        end
        for (int i = 0; i < 3; i++) begin
            if (wr_max[i]) begin
                next_st.max_duty[i] = reg_wdata;
            end
        end
        if (wr_start) begin
            next_st.ramp_start = reg_wdata;
        end
        if (wr_span) begin
            next_st.ramp_span = reg_wdata & `CTF_WMASK_RAMP_SPAN;
        end
        if (cpu_temp_valid) begin
            next_st.cpu_temp = cpu_temp;
        end
        if (reg_rd) begin
            case (reg_addr)
                `CTF_ADDR_LINK_CFG: next_st.rdata = st.link_cfg;
                `CTF_ADDR_FAN1_MAX: next_st.rdata = st.max_duty[0];
                `CTF_ADDR_FAN2_MAX: next_st.rdata = st.max_duty[1];
                `CTF_ADDR_FAN3_MAX: next_st.rdata = st.max_duty[2];
                `CTF_ADDR_RAMP_START: next_st.rdata = st.ramp_start;
                `CTF_ADDR_RAMP_SPAN: next_st.rdata = st.ramp_span;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.link_cfg <= `CTF_RST_LINK_CFG;
            st.max_duty <= {3{`CTF_RST_MAX_DUTY}};
            st.ramp_start <= `CTF_RST_RAMP_START;
            st.ramp_span <= `CTF_RST_RAMP_SPAN;
            st.cpu_temp <= 8'h00;
            st.rdata <= 8'h00;
            st.rvalid <= 1'b0;
            st.poll_req <= 1'b0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // link controls
    // ----------------------------------------
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign poll_req = st.poll_req;
    assign retry_allow = !st.link_cfg[`CTF_BIT_RETRY_SUP];
    assign cpu_wr_grant = cpu_wr_req && st.link_cfg[`CTF_BIT_WR_PERMIT];

    ctf_poll_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .enable(cpu_poll_enable),
        .rate_sel(st.link_cfg[`CTF_RATE_HI:`CTF_RATE_LO]),
        .tick(tick)
    );

    // ----------------------------------------
    // fan ramps
    // ----------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_ramp
        ctf_duty_ramp u_ramp (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .clk_en(clk_en),
            .temp(st.cpu_temp),
            .start_temp(st.ramp_start),
            .ramp_span_sel(st.ramp_span[`CTF_SPAN_HI:`CTF_SPAN_LO]),
            .floor_duty(floor_duty[g]),
            .max_duty(st.max_duty[g]),
            .duty(auto_duty[g])
        );
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_found_follows_link;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && detect_done |=> st.link_cfg[`CTF_BIT_FOUND] == $past(detect_found);
    endproperty
    a_found_follows_link: assert property (p_found_follows_link) else $error("found flag not from link");

    property p_retry_from_write;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_link |=> retry_allow == !$past(reg_wdata[`CTF_BIT_RETRY_SUP]);
    endproperty
    a_retry_from_write: assert property (p_retry_from_write) else $error("retry control wrong");

    property p_rate_stored;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_link |=> st.link_cfg[5:4] == $past(reg_wdata[5:4]);
    endproperty
    a_rate_stored: assert property (p_rate_stored) else $error("poll rate not stored");

    property p_write_gate;
        @(posedge core_clk) disable iff (!arst_n)
        cpu_wr_grant |-> cpu_wr_req && st.link_cfg[`CTF_BIT_WR_PERMIT];
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("cpu write without permit");

    property p_write_off;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_link && !reg_wdata[`CTF_BIT_WR_PERMIT] |=> !cpu_wr_grant;
    endproperty
    a_write_off: assert property (p_write_off) else $error("cpu write granted after permit cleared");

    property p_link_reset;
        @(posedge core_clk)
        $rose(arst_n) |-> st.link_cfg == `CTF_RST_LINK_CFG;
    endproperty
    a_link_reset: assert property (p_link_reset) else $error("link config reset value wrong");

    property p_link_reserved;
        @(posedge core_clk) disable iff (!arst_n)
        reg_rvalid && $past(reg_addr) == `CTF_ADDR_LINK_CFG |-> reg_rdata[3:2] == 2'h0;
    endproperty
    a_link_reserved: assert property (p_link_reserved) else $error("reserved link bits read nonzero");

    property p_cap_write;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_max[1] ##1 clk_en && reg_rd && reg_addr == `CTF_ADDR_FAN2_MAX |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("fan cap readback wrong");

    property p_span_reserved;
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_span |=> st.ramp_span[3:0] == 4'h0 && st.ramp_span[7:4] == $past(reg_wdata[7:4]);
    endproperty
    a_span_reserved: assert property (p_span_reserved) else $error("span register write wrong");

    property p_poll_gate;
        @(posedge core_clk) disable iff (!arst_n)
        poll_req |-> $past(cpu_poll_enable);
    endproperty
    a_poll_gate: assert property (p_poll_gate) else $error("poll without enable");

    property p_start_reset;
        @(posedge core_clk)
        $rose(arst_n) |-> st.ramp_start == `CTF_RST_RAMP_START;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("ramp start reset value wrong");
endmodule // ctf_cpu_thermal_fan_config_regs

//--- dv/ctf_link_model.sv
// behavioural model of the thermal link engine beside the register bank
`timescale 1ns/1ns
module ctf_link_model (
    input wire logic core_clk,
    input wire logic poll_req,
    input wire logic cpu_wr_grant,
    output logic detect_done,
    output logic detect_found,
    output logic [7:0] cpu_temp,
    output logic cpu_temp_valid,
    output logic cpu_wr_req
);
    // poll requests seen, for the bench to count
    int poll_count = 0;

    always @(posedge core_clk) begin
        if (poll_req === 1'b1) begin
            poll_count <= poll_count + 1;
        end
    end

    initial begin
        detect_done = 1'b0;
        detect_found = 1'b1;
        cpu_temp = 8'h00;
        cpu_temp_valid = 1'b0;
        cpu_wr_req = 1'b0;
    end

    // ----------------------------------------
    // link events, driven off the falling edge
    // ----------------------------------------
    // result of a processor search; found only qualifies the done pulse
    task automatic detect(input logic found);
        @(negedge core_clk);
        detect_done = 1'b1;
        detect_found = found;
        @(negedge core_clk);
        detect_done = 1'b0;
        detect_found = ~found;
    endtask

    // one temperature reading; data is scrambled once the pulse is gone
    task automatic push_temp(input logic [7:0] t);
        @(negedge core_clk);
        cpu_temp = t;
        cpu_temp_valid = 1'b1;
        @(negedge core_clk);
        cpu_temp_valid = 1'b0;
        cpu_temp = ~t;
    endtask

    // asks to write the cpu; the model only holds the request and never looks at the grant
    task automatic want_write(input logic req);
        @(negedge core_clk);
        cpu_wr_req = req;
    endtask
endmodule // ctf_link_model

//--- dv/testbench.sv
// self-checking testbench for the cpu thermal fan register bank
`timescale 1ns/1ns
`include "ctf_cfg.svh"
module testbench;
    localparam int CPM = 10;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic detect_done, detect_found, cpu_temp_valid, cpu_wr_req;
    logic [7:0] cpu_temp;
    logic cpu_poll_enable = 1'b0;
    logic poll_req, retry_allow, cpu_wr_grant;
    logic [2:0][7:0] floor_duty = {3{8'h20}};
    logic [2:0][7:0] auto_duty;
    int err_count = 0;
    int compares = 0;

    always #5 core_clk = ~core_clk;

    ctf_cpu_thermal_fan_config_regs #(.CYC_PER_MS(CPM)) ctf_cpu_thermal_fan_config_regs_i (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .detect_done(detect_done), .detect_found(detect_found),
        .cpu_poll_enable(cpu_poll_enable), .cpu_temp(cpu_temp), .cpu_temp_valid(cpu_temp_valid),
        .poll_req(poll_req), .retry_allow(retry_allow), .cpu_wr_req(cpu_wr_req),
        .cpu_wr_grant(cpu_wr_grant), .floor_duty(floor_duty), .auto_duty(auto_duty));

    ctf_link_model ctf_link_model_i (
        .core_clk(core_clk), .poll_req(poll_req), .cpu_wr_grant(cpu_wr_grant),
        .detect_done(detect_done), .detect_found(detect_found), .cpu_temp(cpu_temp),
        .cpu_temp_valid(cpu_temp_valid), .cpu_wr_req(cpu_wr_req));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check({31'h0, reg_rvalid}, 32'h1);
        check({24'h0, reg_rdata}, {24'h0, exp});
    endtask

    task automatic close_out();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        rd(`CTF_ADDR_LINK_CFG, 8'h32);
        rd(`CTF_ADDR_FAN1_MAX, 8'hFF);
        rd(`CTF_ADDR_FAN2_MAX, 8'hFF);
        rd(`CTF_ADDR_FAN3_MAX, 8'hFF);
        rd(`CTF_ADDR_RAMP_START, 8'h80);
        rd(`CTF_ADDR_RAMP_SPAN, 8'hC0);
        rd(8'h40, 8'h00);
        check({31'h0, retry_allow}, 32'h0);
        ctf_link_model_i.want_write(1'b1);
        #1 check({31'h0, cpu_wr_grant}, 32'h0);
        $display("test reset_values done");
    endtask

    task automatic t_masks_and_grants();
        wr(`CTF_ADDR_LINK_CFG, 8'hFF);
        rd(`CTF_ADDR_LINK_CFG, 8'hB3);
        check({31'h0, cpu_wr_grant}, 32'h1);
        check({31'h0, retry_allow}, 32'h0);
        wr(`CTF_ADDR_RAMP_SPAN, 8'hFF);
        rd(`CTF_ADDR_RAMP_SPAN, 8'hF0);
        wr(`CTF_ADDR_LINK_CFG, 8'h00);
        check({31'h0, retry_allow}, 32'h1);
        check({31'h0, cpu_wr_grant}, 32'h0);
        ctf_link_model_i.want_write(1'b0);
        wr(`CTF_ADDR_LINK_CFG, 8'h80);
        check({31'h0, cpu_wr_grant}, 32'h0);
        $display("test masks_and_grants done");
    endtask

    task automatic t_detect();
        ctf_link_model_i.detect(1'b1);
        rd(`CTF_ADDR_LINK_CFG, 8'h81);
        ctf_link_model_i.detect(1'b0);
        rd(`CTF_ADDR_LINK_CFG, 8'h80);
        $display("test detect done");
    endtask

    task automatic t_caps();
        // write then read at the very next edge
        @(negedge core_clk);
        reg_addr = `CTF_ADDR_FAN2_MAX;
        reg_wdata = 8'h5A;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check({24'h0, reg_rdata}, 32'h5A);
        wr(`CTF_ADDR_FAN1_MAX, 8'hA0);
        wr(`CTF_ADDR_FAN2_MAX, 8'hA0);
        wr(`CTF_ADDR_FAN3_MAX, 8'hA0);
        // a write while the clock enable is low is not taken
        clk_en = 1'b0;
        wr(`CTF_ADDR_FAN1_MAX, 8'h55);
        clk_en = 1'b1;
        rd(`CTF_ADDR_FAN1_MAX, 8'hA0);
        rd(`CTF_ADDR_FAN3_MAX, 8'hA0);
        $display("test caps done");
    endtask

    task automatic poll_rate(input logic [1:0] code, input int period);
        int n;
        wr(`CTF_ADDR_LINK_CFG, {2'b00, code, 4'h0});
        cpu_poll_enable = 1'b0;
        @(negedge core_clk);
        cpu_poll_enable = 1'b1;
        n = 0;
        while (poll_req !== 1'b1 && n < period + 20) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (poll_req !== 1'b1 && n < period + 20);
        check(n, period);
    endtask

    task automatic t_poll();
        int n;
        int p;
        poll_rate(2'b00, CPM * 1000);
        poll_rate(2'b01, CPM * 500);
        poll_rate(2'b10, CPM * 200);
        poll_rate(2'b11, CPM * 100);
        cpu_poll_enable = 1'b0;
        @(negedge core_clk);
        p = ctf_link_model_i.poll_count;
        n = 0;
        repeat (3000) begin
            @(negedge core_clk);
            if (poll_req !== 1'b0) n++;
        end
        check(n, 0);
        check(ctf_link_model_i.poll_count - p, 0);
        $display("test poll done");
    endtask

    task automatic ramp_case(input logic [7:0] start, input logic [3:0] code,
                             input logic [7:0] t, input logic [7:0] exp);
        wr(`CTF_ADDR_RAMP_START, start);
        wr(`CTF_ADDR_RAMP_SPAN, {code, 4'h0});
        ctf_link_model_i.push_temp(t);
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 3; i++) begin
            check({24'h0, auto_duty[i]}, {24'h0, exp});
        end
    endtask

    task automatic t_ramp();
        ramp_case(8'h10, 4'hC, 8'h10, 8'h00);
        ramp_case(8'h10, 4'hC, 8'h20, 8'h60);
        ramp_case(8'h10, 4'hC, 8'h40, 8'hA0);
        ramp_case(8'h10, 4'h0, 8'h11, 8'h60);
        ramp_case(8'h10, 4'h0, 8'h12, 8'hA0);
        ramp_case(8'h10, 4'h3, 8'h12, 8'h60);
        ramp_case(8'h10, 4'h9, 8'h18, 8'h60);
        ramp_case(8'hF0, 4'h4, 8'hE0, 8'h00);
        $display("test ramp done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        t_reset_values();
        t_masks_and_grants();
        t_detect();
        t_caps();
        t_ramp();
        t_poll();
        close_out();
    end

    initial begin
        #800000;
        err_count++;
        close_out();
    end
endmodule // testbench
